// ===== hdl/lvdc_regs.vh
// register map and field positions of the low-voltage detect control block
// assumes byte addresses on a 32-bit apb, one word per register
`ifndef LVDC_REGS_VH
`define LVDC_REGS_VH
// printed offsets are not multiples of four: they are indices, byte = 4*index
`define LVDC_IDX_CTRL 16'hff86
`define LVDC_IDX_STAT 16'hff87
`define LVDC_IDX_CNT 16'hffc3
`define LVDC_IDX_IEN 16'hff88
`define LVDC_IDX_ICLR 16'hff89
`define LVDC_ADDR_W 18
`define LVDC_CTRL_ON 7
`define LVDC_CTRL_DSRC 5
`define LVDC_CTRL_USRC 4
`define LVDC_CTRL_RSEL 3
`define LVDC_CTRL_RSTEN 2
`define LVDC_CTRL_DIE 1
`define LVDC_CTRL_UIE 0
`define LVDC_CTRL_MASK 8'hbf
`define LVDC_STAT_SETTLED 7
`define LVDC_STAT_REFSRC 3
`define LVDC_STAT_DROP 1
`define LVDC_STAT_RISE 0
`define LVDC_RST_VAL 8'h00
`define LVDC_EV_SETTLED 0
`define LVDC_EV_DROP 1
`define LVDC_EV_RISE 2
`define LVDC_EV_RESET 3
`define LVDC_PRESCALE 2'h3
`endif

// ===== hdl/lvdc_sync.v
// three-stage synchroniser for a group of asynchronous levels
// assumes one system clock; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module lvdc_sync #(
	parameter W = 4
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : bit_g
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					s1_q[g] <= 1'b0;
					s2_q[g] <= 1'b0;
					s3_q[g] <= 1'b0;
					q_o[g] <= 1'b0;
				end else begin
					s1_q[g] <= d_i[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					// filters a single-cycle glitch past stage one
					if (s2_q[g] == s3_q[g]) begin
						q_o[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== hdl/lvdc_top.v
// control and status logic of the supply-voltage monitor, apb slave
// assumes analog comparators deliver raw levels; hard reset from por/watchdog
//
// Functional notes
// - bit 7 turns detector on, else standby
// - bit 5 picks drop level source
// - bit 4 picks rise level source
// - bit 3 picks reset threshold 2.3/3.3 V
// - bit 2 gates the low-voltage reset
// - bit 1 enables drop interrupt
// - bit 0 enables rise interrupt
// - on, threshold, reset-enable survive detector reset
// - control reads zero after init, all bits writable except bit 6, which reads zero
// - status 7 set on counter overflow
// - status 3 picks reference source
// - status 1 set on drop
// - status 0 set on drop-then-recover sequence, armed only if bit 0 is set at the drop
// - detector reset clears the status flags
// - 8-bit counter at clock/4 from enable
// - enabled requests drive interrupt line zero
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_regs.vh"
module lvdc_top (
	// clock and hard reset
	input wire SYS_CLK_I,
	input wire RST_N_I,
	// apb slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [`LVDC_ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [3:0] PSTRB_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	// raw comparator levels, asynchronous
	input wire DROP_CMP_I,
	input wire RISE_CMP_I,
	input wire RESET_CMP_I,
	// analog steering and reset
	output reg DETECTOR_ON_O,
	output reg DROP_LEVEL_SRC_SEL_O,
	output reg RISE_LEVEL_SRC_SEL_O,
	output reg RESET_THRESHOLD_SEL_O,
	output reg REF_SRC_SEL_O,
	output reg LV_RESET_O,
	// interrupts
	output reg EXT_IRQ_ZERO_O,
	output reg IRQ_O
);
	localparam [1:0] SEQ_IDLE = 2'b01;
	localparam [1:0] SEQ_ARMED = 2'b10;
	reg [7:0] ctrl_q;
	reg ref_src_q;
	reg [2:0] flag_q;
	reg [2:0] seen_q;
	reg [7:0] cnt_q;
	reg [1:0] pre_q;
	reg [1:0] seq_q;
	reg [1:0] seq_d;
	reg dropped_q;
	reg [3:0] ev_q;
	reg [3:0] ien_q;
	reg lvr_q;
	wire [2:0] cmp_s;
	wire drop_s;
	wire rise_s;
	wire rst_s;
	wire wr;
	wire rd;
	wire [15:0] idx;
	wire ovf;
	wire ev_drop;
	wire ev_rise;
	wire [2:0] fset;
	wire [7:0] stat_rd;
	wire [3:0] ev_set;
	wire [3:0] ev_clr;
	wire armed;
	wire stat_rd_acc;
	wire [2:0] rd_ones;
	wire drop_req;
	wire rise_req;
	reg [7:0] rd_d;
	reg hit_d;

	function hit_reg;
		input [15:0] a;
		input [15:0] r;
		begin
			hit_reg = (a == r);
		end
	endfunction

	lvdc_sync #(
		.W(3)
	) u_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.d_i({RESET_CMP_I, RISE_CMP_I, DROP_CMP_I}),
		.q_o(cmp_s)
	);

	assign drop_s = cmp_s[0] & ctrl_q[`LVDC_CTRL_ON];
	assign rise_s = cmp_s[1] & ctrl_q[`LVDC_CTRL_ON];
	assign rst_s = cmp_s[2] & ctrl_q[`LVDC_CTRL_ON];

	// single-cycle accesses: ready on the access phase itself
	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd = PSEL_I & PENABLE_I & ~PWRITE_I;
	assign idx = PADDR_I[`LVDC_ADDR_W-1:2];

	// overflow from all ones at prescale end
	assign ovf = ctrl_q[`LVDC_CTRL_ON] & (pre_q == `LVDC_PRESCALE) &
		(cnt_q == 8'hff);
	// drop flag on falling to threshold
	assign ev_drop = drop_s & ~dropped_q;
	assign armed = (seq_q == SEQ_ARMED);
	assign ev_rise = armed & rise_s & ~rst_s;
	assign fset = {ovf, ev_drop, ev_rise};

	assign stat_rd = {flag_q[2], 3'h0, ref_src_q, 1'b0, flag_q[1], flag_q[0]};
	assign ev_set = {lvr_q, ev_rise, ev_drop, ovf};
	assign ev_clr = (wr && PSTRB_I[0] && hit_reg(idx, `LVDC_IDX_ICLR)) ?
		PWDATA_I[3:0] : 4'h0;

	// only ones really returned count, not later sets
	assign stat_rd_acc = rd & PREADY_O & hit_reg(idx, `LVDC_IDX_STAT);
	assign rd_ones = stat_rd_acc ? {PRDATA_O[7], PRDATA_O[1:0]} : 3'h0;

	// drop request gated by its enable
	assign drop_req = flag_q[1] & ctrl_q[`LVDC_CTRL_DIE];
	// rise request gated by its enable
	assign rise_req = flag_q[0] & ctrl_q[`LVDC_CTRL_UIE];

	// a new armed drop wins over disarming
	always @* begin
		seq_d = seq_q;
		case (seq_q)
			SEQ_IDLE: begin
				if (ev_drop && ctrl_q[`LVDC_CTRL_UIE]) begin
					seq_d = SEQ_ARMED;
				end
			end
			SEQ_ARMED: begin
				if (ev_drop && ctrl_q[`LVDC_CTRL_UIE]) begin
					seq_d = SEQ_ARMED;
				end else if (ev_rise || rst_s || lvr_q) begin
					seq_d = SEQ_IDLE;
				end
			end
			default: begin
				seq_d = SEQ_IDLE;
			end
		endcase
	end

	always @* begin
		rd_d = 8'h00;
		hit_d = 1'b1;
		case (1'b1)
			hit_reg(idx, `LVDC_IDX_CTRL): rd_d = ctrl_q;
			hit_reg(idx, `LVDC_IDX_STAT): rd_d = stat_rd;
			hit_reg(idx, `LVDC_IDX_CNT): rd_d = cnt_q;
			hit_reg(idx, `LVDC_IDX_IEN): rd_d = {4'h0, ien_q};
			hit_reg(idx, `LVDC_IDX_ICLR): rd_d = 8'h00;
			default: hit_d = 1'b0;
		endcase
	end

	// apb answer
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I & ~PENABLE_I;
			PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit_d;
			PRDATA_O <= 32'h0000_0000;
			if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
				PRDATA_O <= {24'h000000, rd_d};
			end
		end
	end

	// control register
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			// all control bits zero at init
			ctrl_q <= `LVDC_RST_VAL;
			ref_src_q <= 1'b0;
			ien_q <= 4'h0;
		end else begin
			if (lvr_q) begin
				ctrl_q[`LVDC_CTRL_DSRC] <= 1'b0;
				ctrl_q[`LVDC_CTRL_USRC] <= 1'b0;
				ctrl_q[`LVDC_CTRL_DIE] <= 1'b0;
				ctrl_q[`LVDC_CTRL_UIE] <= 1'b0;
				ref_src_q <= 1'b0;
			end else if (wr && PREADY_O && PSTRB_I[0]) begin
				if (hit_reg(idx, `LVDC_IDX_CTRL)) begin
					ctrl_q <= PWDATA_I[7:0] & `LVDC_CTRL_MASK;
				end
				if (hit_reg(idx, `LVDC_IDX_STAT)) begin
					ref_src_q <= PWDATA_I[`LVDC_STAT_REFSRC];
				end
				if (hit_reg(idx, `LVDC_IDX_IEN)) begin
					ien_q <= PWDATA_I[3:0];
				end
			end
		end
	end

	// settle counter, prescaler, drop tracking
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I || !ctrl_q[`LVDC_CTRL_ON]) begin
			cnt_q <= 8'h00;
			pre_q <= 2'h0;
			dropped_q <= 1'b0;
			seq_q <= SEQ_IDLE;
		end else begin
			// count at clock divided by four
			pre_q <= pre_q + 2'h1;
			if (pre_q == `LVDC_PRESCALE) begin
				cnt_q <= cnt_q + 8'h01;
			end
			dropped_q <= drop_s;
			// arm only with rise enable set
			seq_q <= seq_d;
		end
	end

	// status flags with read-one-then-write-zero clearing
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			flag_q <= 3'h0;
			seen_q <= 3'h0;
		end else if (lvr_q) begin
			flag_q <= 3'h0;
			seen_q <= 3'h0;
		end else begin
			// clear only after seen; set wins
			if (wr && PREADY_O && PSTRB_I[0] &&
				hit_reg(idx, `LVDC_IDX_STAT)) begin
				flag_q <= (flag_q & ~(seen_q & ~{PWDATA_I[7], PWDATA_I[1:0]}))
					| fset;
				seen_q <= seen_q & {PWDATA_I[7], PWDATA_I[1:0]} & ~fset;
			end else begin
				flag_q <= flag_q | fset;
				// note reads of one; new event voids them
				seen_q <= (seen_q | rd_ones) & ~fset;
			end
		end
	end

	// sticky events, cleared through the clear register; set beats clear
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			ev_q <= 4'h0;
		end else begin
			ev_q <= (ev_q & ~ev_clr) | ev_set;
		end
	end

	// outputs, all registered
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			lvr_q <= 1'b0;
			DETECTOR_ON_O <= 1'b0;
			DROP_LEVEL_SRC_SEL_O <= 1'b0;
			RISE_LEVEL_SRC_SEL_O <= 1'b0;
			RESET_THRESHOLD_SEL_O <= 1'b0;
			REF_SRC_SEL_O <= 1'b0;
			LV_RESET_O <= 1'b0;
			EXT_IRQ_ZERO_O <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			lvr_q <= rst_s & ctrl_q[`LVDC_CTRL_RSTEN];
			LV_RESET_O <= rst_s & ctrl_q[`LVDC_CTRL_RSTEN];
			DETECTOR_ON_O <= ctrl_q[`LVDC_CTRL_ON];
			// drop level from ladder or pin
			DROP_LEVEL_SRC_SEL_O <= ctrl_q[`LVDC_CTRL_DSRC];
			// rise level from ladder or pin
			RISE_LEVEL_SRC_SEL_O <= ctrl_q[`LVDC_CTRL_USRC];
			RESET_THRESHOLD_SEL_O <= ctrl_q[`LVDC_CTRL_RSEL];
			REF_SRC_SEL_O <= ref_src_q;
			EXT_IRQ_ZERO_O <= drop_req | rise_req;
			IRQ_O <= |(ev_q & ien_q);
		end
	end
endmodule
`default_nettype wire

// ===== verif/lvdc_checker.sv
// concurrent checks on the ports of the low-voltage detect control block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_regs.vh"
module lvdc_checker (
	// watched ports
	input wire SYS_CLK_I,
	input wire RST_N_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [`LVDC_ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [3:0] PSTRB_I,
	input wire [31:0] PRDATA_O,
	input wire PREADY_O,
	input wire PSLVERR_O,
	input wire DETECTOR_ON_O,
	input wire RESET_THRESHOLD_SEL_O,
	input wire LV_RESET_O,
	input wire IRQ_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire ctl = PADDR_I == {`LVDC_IDX_CTRL, 2'h0};
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_ctl_wr;
		PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && ctl;
	endsequence
	chk_ready_next: assert property (s_setup |=> PREADY_O)
		else $error("no ready after setup");
	chk_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
		else $error("ready outside access");
	chk_ctl_bits: assert property (PREADY_O && ctl |->
		!PSLVERR_O && PRDATA_O[31:8] == 24'h0 && !PRDATA_O[6])
		else $error("bad control read");
	chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	chk_on_follow: assert property (s_ctl_wr |->
		##2 DETECTOR_ON_O == $past(PWDATA_I[7], 2))
		else $error("detector on mismatch");
	chk_thr_follow: assert property (s_ctl_wr |->
		##2 RESET_THRESHOLD_SEL_O == $past(PWDATA_I[3], 2))
		else $error("threshold select mismatch");
	chk_lvr_gate: assert property ($rose(LV_RESET_O) |->
		DETECTOR_ON_O || $past(DETECTOR_ON_O))
		else $error("reset while detector off");
	chk_reset_quiet: assert property ($rose(RST_N_I) |->
		!DETECTOR_ON_O && !IRQ_O && !LV_RESET_O)
		else $error("outputs not clear after reset");
endmodule
`default_nettype wire

// ===== verif/tb_low_voltage_detect_ctrl.sv
// self-checking bench for the low-voltage detect control block
// assumes lvdc_top with apb answering one cycle after setup
`timescale 1ns/1ps
`default_nettype none
`include "lvdc_regs.vh"
module tb_low_voltage_detect_ctrl;
	logic clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, e;
	logic dcmp = 0, ucmp = 0, rcmp = 0;
	logic [17:0] addr = 0;
	logic [31:0] wdat = 0;
	logic [7:0] q, v;
	wire [31:0] rdat;
	wire rdy, err, on, dsrc, usrc, rsel, refs, lvr, external_irq_line_zero, irq;
	int n_errors = 0, tests_run = 0, i;
	localparam logic [17:0] A_CTL = {`LVDC_IDX_CTRL, 2'h0};
	localparam logic [17:0] A_ST = {`LVDC_IDX_STAT, 2'h0};
	localparam logic [17:0] A_IEN = {`LVDC_IDX_IEN, 2'h0};
	localparam logic [17:0] A_CLR = {`LVDC_IDX_ICLR, 2'h0};
	localparam logic [17:0] A_CNT = {`LVDC_IDX_CNT, 2'h0};
	lvdc_top uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(sel),
		.PENABLE_I(en), .PWRITE_I(wr), .PADDR_I(addr), .PWDATA_I(wdat),
		.PSTRB_I(4'hf), .PRDATA_O(rdat), .PREADY_O(rdy), .PSLVERR_O(err),
		.DROP_CMP_I(dcmp), .RISE_CMP_I(ucmp), .RESET_CMP_I(rcmp),
		.DETECTOR_ON_O(on), .DROP_LEVEL_SRC_SEL_O(dsrc),
		.RISE_LEVEL_SRC_SEL_O(usrc), .RESET_THRESHOLD_SEL_O(rsel),
		.REF_SRC_SEL_O(refs), .LV_RESET_O(lvr), .EXT_IRQ_ZERO_O(external_irq_line_zero),
		.IRQ_O(irq));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		tests_run++;
		if (g !== x) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// request held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		sel <= 1;
		en <= 0;
		wr <= w;
		addr <= a;
		wdat <= {24'h0, d};
		@(posedge clk);
		en <= 1;
		// wait states allowed: ready taken as it stood at the edge
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		q = rdat[7:0];
		e = err;
		sel <= 0;
		en <= 0;
		@(posedge clk);
	endtask
	// settle count at a setup edge k cycles after the enabling write
	function automatic logic [7:0] exp_cnt(input int k);
		return 8'((k - 1) / 4);
	endfunction
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		complete_run();
	end
	initial begin
		v = $urandom(32'h5d85ead5);
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		apb(0, A_CTL, 0); chk(q, 0);
		apb(0, A_ST, 0); chk(q, 0);
		apb(0, 18'h00010, 0); chk({e, q[6:0]}, 8'h80);
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h7f : $urandom & 8'h7f;
			apb(1, A_CTL, v);
			apb(0, A_CTL, 0); chk(q, v & `LVDC_CTRL_MASK);
			chk({5'h0, dsrc, usrc, rsel}, {5'h0, v[5:3]});
		end
		apb(1, A_CTL, 8'h03);
		dcmp <= 1;
		repeat (10) @(posedge clk);
		apb(0, A_ST, 0); chk(q & 8'h03, 0);
		dcmp <= 0;
		apb(1, A_ST, 8'h08);
		apb(0, A_ST, 0); chk({refs, 3'h0, q[3:0]}, 8'h88);
		apb(1, A_CTL, 8'h80);
		rcmp <= 1;
		repeat (10) @(posedge clk);
		chk({7'h0, lvr}, 0);
		chk({7'h0, on}, 1);
		rcmp <= 0;
		repeat (959) @(posedge clk);
		apb(0, A_CNT, 0); chk(q, exp_cnt(971));
		apb(0, A_ST, 0); chk(q & 8'h80, 0);
		repeat (80) @(posedge clk);
		apb(0, A_ST, 0); chk(q & 8'h80, 8'h80);
		apb(1, A_ST, 0);
		apb(0, A_ST, 0); chk(q & 8'h80, 0);
		apb(1, A_CTL, 8'h83);
		apb(1, A_IEN, 8'h02);
		dcmp <= 1;
		repeat (10) @(posedge clk);
		chk({6'h0, external_irq_line_zero, irq}, 8'h03);
		apb(1, A_ST, 0);
		apb(0, A_ST, 0); chk(q & 8'h03, 8'h02);
		apb(1, A_ST, 0);
		apb(0, A_ST, 0); chk(q & 8'h03, 0);
		apb(1, A_IEN, 0);
		repeat (4) @(posedge clk);
		chk({6'h0, external_irq_line_zero, irq}, 0);
		apb(1, A_IEN, 8'h02);
		repeat (4) @(posedge clk);
		chk({7'h0, irq}, 1);
		apb(1, A_CLR, 8'h02);
		repeat (4) @(posedge clk);
		chk({7'h0, irq}, 0);
		ucmp <= 1;
		repeat (10) @(posedge clk);
		apb(0, A_ST, 0); chk(q & 8'h03, 8'h01);
		chk({7'h0, external_irq_line_zero}, 1);
		dcmp <= 0;
		ucmp <= 0;
		apb(1, A_CTL, 8'hbf);
		rcmp <= 1;
		repeat (10) @(posedge clk);
		chk({7'h0, lvr}, 1);
		rcmp <= 0;
		repeat (10) @(posedge clk);
		apb(0, A_CTL, 0); chk(q, 8'h8c);
		apb(0, A_ST, 0); chk(q & 8'h0b, 0);
		complete_run();
	end
endmodule
bind lvdc_top lvdc_checker chk (.SYS_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I,
	.PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O,
	.PSLVERR_O, .DETECTOR_ON_O, .RESET_THRESHOLD_SEL_O, .LV_RESET_O, .IRQ_O);
`default_nettype wire
